// *** pkg/mdcs_params.svh ***
// Constants of the management serial control block: offsets, fields,
// reset values and frame timing.
// Assumes a 32-bit APB register port with one word per register.
`ifndef MDCS_PARAMS_SVH
`define MDCS_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MDCS_OFS_IDENT 12'h000
`define MDCS_OFS_CTRL 12'h004
`define MDCS_OFS_ACK 12'h008
`define MDCS_OFS_IRQ_STS 12'h030
`define MDCS_OFS_IRQ_MASK 12'h034

// ****************************************************************
// Control register fields
// ****************************************************************
`define MDCS_CTRL_IDLE 31
`define MDCS_CTRL_ENABLE 30
`define MDCS_CTRL_CHAN_LO 24
`define MDCS_CTRL_PREAMBLE_OFF 20
`define MDCS_CTRL_FAULT 19
`define MDCS_CTRL_FAULT_EN 18
`define MDCS_HIGHEST_CHANNEL 5'h01
`define MDCS_DIV_RESET 16'h00FF

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define MDCS_IRQ_DONE 0
`define MDCS_IRQ_FAULT 1

// ****************************************************************
// Frame layout, bit positions within one 64-bit frame
// ****************************************************************
`define MDCS_BIT_START 6'd0
`define MDCS_BIT_HEADER 6'd32
`define MDCS_BIT_PHY 6'd36
`define MDCS_BIT_REG 6'd41
`define MDCS_BIT_TA0 6'd46
`define MDCS_BIT_TA1 6'd47
`define MDCS_BIT_DATA 6'd48
`define MDCS_BIT_LAST 6'd63

`endif

// *** pkg/mdcs_pkg.sv ***
// Types of the management serial control block.
// Assumes the constants header is included by each user.
package mdcs_pkg;

    // ************************************************************
    // Frame engine states
    // ************************************************************
    typedef enum logic {
        MDCS_IDLE,
        MDCS_FRAME
    } mdcs_state_e;

    // ************************************************************
    // Whole state of the block
    // ************************************************************
    typedef struct packed {
        mdcs_state_e state;   // Frame engine state
        logic enable;         // Engine enable
        logic preamble_off;   // Preamble suppression
        logic fault;          // Pin readback fault flag
        logic fault_en;       // Fault detection enable
        logic [15:0] div;     // Clock divider
        logic [15:0] div_cnt; // Divider phase counter
        logic mdc;            // Serial clock level
        logic armed;          // First bit of frame driven
        logic [5:0] bit_idx;  // Current frame bit
        logic op_write;       // Frame is a write
        logic op_poll;        // Frame came from polling
        logic [4:0] phy;      // Target PHY address
        logic [4:0] regad;    // Target register address
        logic [15:0] wdata;   // Write data
        logic [15:0] rdata;   // Read data shift register
        logic ack_ok;         // PHY acknowledged turnaround
        logic mdio_o;         // Serial data output level
        logic mdio_oe;        // Serial data output enable
        logic [31:0] ack;     // Per-address acknowledge bits
        logic [1:0] irq_sts;  // Sticky interrupt events
        logic [1:0] irq_mask; // Interrupt mask
        logic [31:0] prdata;  // Registered read data
        logic done;           // Completion pulse
        logic done_ack;       // Completion acknowledge result
    } mdcs_state_s;

endpackage : mdcs_pkg

// *** core/mdcs_core.sv ***
// Management serial master: identification, control and acknowledge
// status registers over APB, plus the frame engine they steer.
// Assumes pins are synchronous to pclk and requests come from the
// user-access and polling logic outside this file.
//
// Operation
// (RL1) Identification high half holds module type
// (RL2) Identification second byte holds major revision
// (RL3) Identification low byte holds minor revision
// (RL4) Control bit 31 reads engine idle
// (RL5) Control bit 30 enables the engine
// (RL6) Disable mid-frame finishes frame, then idles
// (RL7) Bits 28-24 read highest channel, one
// (RL8) Control bit 20 suppresses frame preamble
// (RL9) Pin readback mismatch sets fault, resets engine
// (RL10) Fault flag cleared by writing one
// (RL11) Control bit 18 gates fault detection
// (RL12) Serial clock is pclk over divider plus one
// (RL13) Divider zero stops the serial clock
// (RL14) Acknowledge register resets zero, write-one clears
// (RL15) Acknowledge bit follows last access result
// (RL16) User and polling accesses both update it
// (RL17) Reserved control bits read zero
`timescale 1ns/1ps
`include "mdcs_params.svh"

module mdcs_core
    import mdcs_pkg::*;
#(
    parameter logic [15:0] MODULE_TYPE_CODE = 16'h00A5, // Arbitrary value
    parameter logic [7:0] MAJOR_REVISION = 8'h02,       // Arbitrary value
    parameter logic [7:0] MINOR_REVISION = 8'h00        // Arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Access requests from user channels and the poller
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_poll,
    input wire logic [4:0] req_phy,
    input wire logic [4:0] req_reg,
    input wire logic [15:0] req_wdata,
    output logic done,
    output logic done_ack,
    output logic done_poll,
    output logic [4:0] done_phy,
    output logic [15:0] done_rdata,

    // Serial pins
    output logic mgmt_serial_clock,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic mdio_i,

    // Interrupt
    output logic irq
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Register select code: 0 ident, 1 ctrl, 2 ack, 3 irq sts,
    // 4 irq mask, 7 unmapped
    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        case (a)
            `MDCS_OFS_IDENT: reg_sel = 3'h0;
            `MDCS_OFS_CTRL: reg_sel = 3'h1;
            `MDCS_OFS_ACK: reg_sel = 3'h2;
            `MDCS_OFS_IRQ_STS: reg_sel = 3'h3;
            `MDCS_OFS_IRQ_MASK: reg_sel = 3'h4;
            default: reg_sel = 3'h7;
        endcase
    endfunction : reg_sel

    // Output enable and level for one frame bit; MSB-first fields
    function automatic logic [1:0] frame_bit(
        input logic [5:0] idx,
        input logic wr,
        input logic [4:0] phy,
        input logic [4:0] regad,
        input logic [15:0] wd
    );
        logic [5:0] off;
        off = 6'h00;

        if (idx < `MDCS_BIT_HEADER) begin
            // Preamble: all ones
            frame_bit = 2'b11;
        end else if (idx < `MDCS_BIT_HEADER + 6'd2) begin
            // Start code 01
            frame_bit = {1'b1, idx[0]};
        end else if (idx < `MDCS_BIT_PHY) begin
            // Opcode: write 01, read 10
            frame_bit = {1'b1, idx[0] ? wr : ~wr};
        end else if (idx < `MDCS_BIT_REG) begin
            off = idx - `MDCS_BIT_PHY;
            frame_bit = {1'b1, phy[3'(3'd4 - off[2:0])]};
        end else if (idx < `MDCS_BIT_TA0) begin
            off = idx - `MDCS_BIT_REG;
            frame_bit = {1'b1, regad[3'(3'd4 - off[2:0])]};
        end else if (!wr) begin
            // Read: release for turnaround and data
            frame_bit = 2'b00;
        end else if (idx == `MDCS_BIT_TA0) begin
            frame_bit = 2'b11;
        end else if (idx == `MDCS_BIT_TA1) begin
            frame_bit = 2'b10;
        end else begin
            off = `MDCS_BIT_LAST - idx;
            frame_bit = {1'b1, wd[off[3:0]]};
        end
    endfunction : frame_bit

    // ************************************************************
    // State and combinational helpers
    // ************************************************************
    mdcs_state_s s_q;     // Registered state
    mdcs_state_s s_d;     // Next state

    logic [2:0] sel;      // Decoded register
    logic setup_ph;       // APB setup cycle
    logic wr_acc;         // APB write completes
    logic rd_acc;         // APB read completes

    logic [15:0] cnt_nx;  // Next divider count

    logic [16:0] half;    // High time of serial clock
    logic mdc_nx;         // Next serial clock level
    logic rise;           // Serial clock rising edge this cycle
    logic fall;           // Serial clock falling edge this cycle

    logic [1:0] fb;       // Frame bit for current index
    logic fault_hit;      // Readback mismatch seen
    logic done_ev;        // Frame completes this cycle
    logic [31:0] ctrl_rd; // Control register read view

    assign sel = reg_sel(paddr);

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    // Zero wait state; read data was latched in the setup cycle
    assign pready = 1'b1;

    assign pslverr = psel && penable && (sel == 3'h7);
    assign prdata = s_q.prdata;

    // New frames only when enabled, idle and clock running
    assign req_ready = (s_q.state == MDCS_IDLE) && s_q.enable // RL5
        && (s_q.div != 16'h0000);

    assign mgmt_serial_clock = s_q.mdc;
    assign mdio_o = s_q.mdio_o;
    assign mdio_oe = s_q.mdio_oe;

    assign done = s_q.done;
    assign done_ack = s_q.done_ack;
    assign done_poll = s_q.op_poll;
    assign done_phy = s_q.phy;
    assign done_rdata = s_q.rdata;

    assign irq = |(s_q.irq_sts & s_q.irq_mask);

    // Control read view; unused positions stay zero
    always_comb begin
        ctrl_rd = 32'h0000_0000; // RL17

        ctrl_rd[`MDCS_CTRL_IDLE] = (s_q.state == MDCS_IDLE); // RL4
        ctrl_rd[`MDCS_CTRL_ENABLE] = s_q.enable;
        ctrl_rd[`MDCS_CTRL_CHAN_LO +: 5] = `MDCS_HIGHEST_CHANNEL; // RL7

        ctrl_rd[`MDCS_CTRL_PREAMBLE_OFF] = s_q.preamble_off;
        ctrl_rd[`MDCS_CTRL_FAULT] = s_q.fault;
        ctrl_rd[`MDCS_CTRL_FAULT_EN] = s_q.fault_en;
        ctrl_rd[15:0] = s_q.div;
    end

    // ************************************************************
    // Serial clock divider
    // ************************************************************

    // One serial period spans div+1 pclk cycles, high for the first
    // half; a zero divider holds the pin low
    always_comb begin
        half = ({1'b0, s_q.div} + 17'h00001) >> 1;

        if (s_q.div == 16'h0000) begin
            cnt_nx = 16'h0000; // RL13
            mdc_nx = 1'b0; // RL13
        end else begin
            cnt_nx = (s_q.div_cnt >= s_q.div) ? 16'h0000 // RL12
                : s_q.div_cnt + 16'h0001;
            mdc_nx = ({1'b0, cnt_nx} < half); // RL12
        end

        rise = mdc_nx && !s_q.mdc;
        fall = !mdc_nx && s_q.mdc;
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Frame engine, register writes, sticky flags and read data
    always_comb begin
        s_d = s_q;
        s_d.div_cnt = cnt_nx;
        s_d.mdc = mdc_nx;
        s_d.done = 1'b0;

        fb = frame_bit(s_q.bit_idx, s_q.op_write, s_q.phy, s_q.regad,
            s_q.wdata);
        fault_hit = 1'b0;
        done_ev = 1'b0;

        // Frame engine
        case (s_q.state)
            MDCS_IDLE: begin
                // Idle always releases the data pin
                s_d.mdio_oe = 1'b0;
                if (req_valid && req_ready) begin
                    s_d.state = MDCS_FRAME;
                    s_d.armed = 1'b0;
                    s_d.bit_idx = s_q.preamble_off ? `MDCS_BIT_HEADER // RL8
                        : `MDCS_BIT_START;

                    s_d.op_write = req_write;
                    s_d.op_poll = req_poll;
                    s_d.phy = req_phy;
                    s_d.regad = req_reg;
                    s_d.wdata = req_wdata;

                    s_d.rdata = 16'h0000;
                    s_d.ack_ok = req_write;
                end
            end
            MDCS_FRAME: begin
                // Enable is not checked here, so a disable lets the
                // current frame run out before the engine halts
                if (fall) begin
                    s_d.mdio_oe = fb[1]; // RL6
                    s_d.mdio_o = fb[0];
                    s_d.armed = 1'b1;
                end else if (rise && s_q.armed) begin
                    // Readback check only while driving
                    if (s_q.fault_en && s_q.mdio_oe // RL11
                        && (mdio_i != s_q.mdio_o)) begin
                        fault_hit = 1'b1; // RL9
                    end

                    if (!s_q.op_write && s_q.bit_idx == `MDCS_BIT_TA1) begin
                        // PHY pulls low in turnaround to acknowledge
                        s_d.ack_ok = !mdio_i;
                    end

                    if (!s_q.op_write && s_q.bit_idx >= `MDCS_BIT_DATA) begin
                        s_d.rdata = {s_q.rdata[14:0], mdio_i};
                    end

                    if (s_q.bit_idx == `MDCS_BIT_LAST) begin
                        done_ev = !fault_hit;
                    end else begin
                        s_d.bit_idx = s_q.bit_idx + 6'd1;
                    end
                end

                if (fault_hit) begin
                    // Physical fault: abandon frame, engine back to idle
                    s_d.state = MDCS_IDLE; // RL9
                    s_d.mdio_oe = 1'b0;
                end else if (done_ev) begin
                    s_d.state = MDCS_IDLE; // RL6
                    s_d.mdio_oe = 1'b0;
                    s_d.done = 1'b1;
                    s_d.done_ack = s_d.ack_ok;
                end
            end
            default: begin
                s_d.state = MDCS_IDLE;
                s_d.mdio_oe = 1'b0;
            end
        endcase

        // Register writes
        if (wr_acc) begin
            case (sel)
                3'h1: begin
                    s_d.enable = pwdata[`MDCS_CTRL_ENABLE]; // RL5
                    s_d.preamble_off = pwdata[`MDCS_CTRL_PREAMBLE_OFF]; // RL8
                    s_d.fault_en = pwdata[`MDCS_CTRL_FAULT_EN]; // RL11
                    s_d.div = pwdata[15:0]; // RL12

                    if (pwdata[`MDCS_CTRL_FAULT]) begin
                        s_d.fault = 1'b0; // RL10
                    end
                end
                3'h2: begin
                    s_d.ack = s_q.ack & ~pwdata; // RL14
                end
                3'h4: begin
                    s_d.irq_mask = pwdata[1:0];
                end
                default: begin
                    // Identification, status and unmapped ignore writes
                end
            endcase
        end

        // Reading interrupt status clears only what the read returned
        if (rd_acc && sel == 3'h3) begin
            s_d.irq_sts = s_q.irq_sts & ~s_q.prdata[1:0];
        end

        // Hardware sets come after clears so a coincident event wins
        if (fault_hit) begin
            s_d.fault = 1'b1; // RL9
            s_d.irq_sts[`MDCS_IRQ_FAULT] = 1'b1;
        end

        if (done_ev) begin
            // Both user and polling frames report their result here
            s_d.ack[s_q.phy] = s_d.ack_ok; // RL15 RL16
            s_d.irq_sts[`MDCS_IRQ_DONE] = 1'b1;
        end

        // Read data is latched in the setup cycle
        if (setup_ph && !pwrite) begin
            case (sel)
                3'h0: s_d.prdata = {MODULE_TYPE_CODE, // RL1
                    MAJOR_REVISION, MINOR_REVISION}; // RL2 RL3
                3'h1: s_d.prdata = ctrl_rd;
                3'h2: s_d.prdata = s_q.ack; // RL14
                3'h3: s_d.prdata = {30'h0000_0000, s_q.irq_sts};
                3'h4: s_d.prdata = {30'h0000_0000, s_q.irq_mask};
                default: s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Single register bank; reset gives idle, disabled, divider 255
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;

            s_q.state <= MDCS_IDLE;
            s_q.div <= `MDCS_DIV_RESET; // RL12
            s_q.ack <= 32'h0000_0000; // RL14
        end else begin
            s_q <= s_d;
        end
    end

endmodule : mdcs_core

// *** dv/mdcs_phy_model.sv ***
// PHY model: answers read frames at one address with ack and a word.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module mdcs_phy_model #(
    parameter logic [4:0] ADDR = 5'h05,
    parameter logic [15:0] WORD = 16'h9E61
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic present,
    input wire logic mdc,
    input wire logic oe_host,
    input wire logic line,
    output logic phy_o,
    output logic phy_oe
);
    logic mdc_q, oe_q, act_q; // Edge history, answer in progress
    logic [13:0] sh_q;        // Last header bits seen
    logic [4:0] cnt_q;        // Falls since the host let go
    // Sample on serial rises, launch on falls; absent PHY never drives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mdc_q, oe_q, act_q, phy_o, phy_oe, sh_q, cnt_q} <= '0;
        end else begin
            mdc_q <= mdc;
            oe_q <= oe_host;
            if (mdc && !mdc_q && oe_host) begin
                sh_q <= {sh_q[12:0], line};
            end
            if (oe_q && !oe_host) begin
                // Host released after start, read code and our address
                act_q <= present && sh_q[13:5] == {4'h6, ADDR};
                cnt_q <= '0;
            end else if (act_q && !mdc && mdc_q) begin
                cnt_q <= cnt_q + 5'h01;
                phy_oe <= cnt_q != 5'h11;
                act_q <= cnt_q != 5'h11;
                phy_o <= cnt_q == 5'h00 ? 1'b0 : WORD[5'h10 - cnt_q];
            end
        end
    end
endmodule : mdcs_phy_model

// *** dv/mdcs_core_assertions.sv ***
// Checker of the core's ports; snoops APB writes for its own copies.
// Assumes one clock domain and writes that land at the access edge.
`timescale 1ns/1ps
`include "mdcs_params.svh"
module mdcs_core_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic done,
    input wire logic mgmt_serial_clock,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    input wire logic mdio_i,
    input wire logic irq
);
    logic [15:0] div_q;
    logic [16:0] per_q; // Cycles since last serial rise
    logic [1:0] msk_q;
    logic en_q, fen_q, clk_q, seen_q, chg_q, wr_c, rise, bad;
    assign wr_c = psel && penable && pwrite && paddr == `MDCS_OFS_CTRL;
    assign rise = mgmt_serial_clock && !clk_q;
    // A restart, gap or fault makes the next period unreliable
    assign bad = per_q > {1'b0, div_q} + 17'h00001 || req_valid && req_ready
        || fen_q && mdio_oe && mdio_i != mdio_o;
    // Shadow of the fields the checks depend on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 16'h00FF;
            {per_q, msk_q, en_q, fen_q, clk_q, seen_q, chg_q} <= '0;
        end else begin
            clk_q <= mgmt_serial_clock;
            per_q <= rise ? 17'h00001 : per_q + 17'h00001;
            chg_q <= wr_c || chg_q && !rise;
            seen_q <= (seen_q || rise) && !bad;
            if (wr_c) begin
                {en_q, fen_q, div_q} <= {pwdata[30], pwdata[18], pwdata[15:0]};
            end
            if (psel && penable && pwrite && paddr == `MDCS_OFS_IRQ_MASK) begin
                msk_q <= pwdata[1:0];
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_accept;
        req_valid && req_ready;
    endsequence
    sequence s_mismatch;
        fen_q && rise && mdio_oe && mdio_i != mdio_o;
    endsequence
    a_clk_period: assert property (
        rise && seen_q && !chg_q |-> per_q == {1'b0, div_q} + 17'h00001)
        else $error("serial clock period wrong");
    a_clk_stops: assert property (
        (div_q == 16'h0000) [*3] |-> !mgmt_serial_clock)
        else $error("serial clock runs with divider zero");
    a_ready_no_div: assert property (
        div_q == 16'h0000 |-> !req_ready)
        else $error("request taken with divider zero");
    a_ready_enable: assert property (
        !en_q |-> !req_ready)
        else $error("request taken while disabled");
    a_busy_accept: assert property (
        s_accept |=> !req_ready [*2])
        else $error("engine not busy after accept");
    a_fault_oe: assert property (
        s_mismatch |-> ##[0:3] !mdio_oe)
        else $error("pin mismatch did not stop the engine");
    a_done_single: assert property (
        done |=> !done)
        else $error("done longer than one cycle");
    a_irq_done: assert property (
        done && msk_q[0] |-> ##[0:1] irq)
        else $error("unmasked completion without interrupt");
endmodule : mdcs_core_assertions
bind mdcs_core mdcs_core_assertions i_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .req_valid, .req_ready, .done,
    .mgmt_serial_clock, .mdio_o, .mdio_oe, .mdio_i, .irq);

// *** dv/mdio_control_status_regs_tb.sv ***
// Bench: APB tasks, request tasks, PHY model on a pulled-up wire.
// Assumes every APB access ends after one access cycle or so.
`timescale 1ns/1ps
`include "mdcs_params.svh"
module mdio_control_status_regs_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic req_valid, req_ready, req_write, req_poll, done, done_ack;
    logic done_poll, mdc, mdio_o, mdio_oe, mdio_i, phy_o, phy_oe;
    logic present, stuck, got;
    logic [4:0] req_phy, req_reg, done_phy;
    logic [15:0] req_wdata, done_rdata;
    int error_cnt, checks_done, cyc, full, tick, all;
    localparam logic [11:0] r_id = `MDCS_OFS_IDENT, r_ct = `MDCS_OFS_CTRL;
    localparam logic [11:0] r_ak = `MDCS_OFS_ACK, r_st = `MDCS_OFS_IRQ_STS;
    localparam logic [11:0] r_mk = `MDCS_OFS_IRQ_MASK;
    // Pull-up wire; stuck models a pin shorted low
    assign mdio_i = stuck ? 1'b0 : mdio_oe ? mdio_o : phy_oe ? phy_o : 1'b1;
    mdcs_core #(.MODULE_TYPE_CODE(16'h0C3D), .MAJOR_REVISION(8'h05),
        .MINOR_REVISION(8'h09)) i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid,
        .req_ready, .req_write, .req_poll, .req_phy, .req_reg, .req_wdata,
        .done, .done_ack, .done_poll, .done_phy, .done_rdata,
        .mgmt_serial_clock(mdc), .mdio_o, .mdio_oe, .mdio_i, .irq);
    mdcs_phy_model i_phy (.pclk(pclk), .presetn(presetn), .present(present),
        .mdc(mdc), .oe_host(mdio_oe), .line(mdio_i), .phy_o(phy_o),
        .phy_oe(phy_oe));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge pclk) begin
        all++;
        if (all > 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Flags are looked at one edge later, once updates have landed
    task automatic flag(ref logic b, input logic e);
        @(posedge pclk);
        chk({31'h0, b}, {31'h0, e});
    endtask : flag
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rd, e);
    endtask : rchk
    task automatic start(input logic w, input logic p, input logic [4:0] a);
        @(posedge pclk);
        {req_valid, req_write, req_poll, req_phy} <= {1'b1, w, p, a};
        @(posedge pclk);
        while (req_ready !== 1'b1) @(posedge pclk);
        req_valid <= 1'b0;
    endtask : start
    task automatic wait_done(input int lim);
        cyc = 0;
        got = 1'b0;
        while (!got && cyc < lim) begin
            @(posedge pclk);
            cyc++;
            got = done === 1'b1;
        end
    endtask : wait_done
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        {psel, penable, pwrite, paddr, pwdata, req_valid} = '0;
        {req_write, req_poll, req_phy, req_reg} = {7'h00, 5'h02};
        {req_wdata, present, stuck, presetn} = {16'h3C5A, 3'b100};
        {error_cnt, checks_done, all} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(r_id, 32'h0C3D0509);
        apb(1'b1, r_id, 32'hFFFFFFFF);
        rchk(r_id, 32'h0C3D0509);
        rchk(r_ct, 32'h810000FF);
        rchk(r_ak, 32'h0);
        rchk(12'h0FC, 32'h0);
        chk(err, 32'h1);
        $display("test reset values done");
        apb(1'b1, r_ct, 32'hFFE30003);
        rchk(r_ct, 32'hC1000003);
        apb(1'b1, r_mk, 32'h3);
        start(1'b0, 1'b0, 5'h05);
        wait_done(2000);
        full = cyc;
        flag(done_ack, 1'b1);
        chk(done_rdata, 32'h9E61);
        chk(done_phy, 32'h5);
        rchk(r_ak, 32'h20);
        apb(1'b1, r_mk, 32'h0);
        flag(irq, 1'b0);
        apb(1'b1, r_mk, 32'h3);
        flag(irq, 1'b1);
        rchk(r_st, 32'h1);
        flag(irq, 1'b0);
        $display("test read frame done");
        apb(1'b1, r_ak, 32'h20);
        rchk(r_ak, 32'h0);
        start(1'b0, 1'b1, 5'h05);
        wait_done(2000);
        flag(done_poll, 1'b1);
        rchk(r_ak, 32'h20);
        present <= 1'b0;
        start(1'b0, 1'b0, 5'h05);
        wait_done(2000);
        flag(done_ack, 1'b0);
        rchk(r_ak, 32'h0);
        present <= 1'b1;
        $display("test acknowledge bits done");
        apb(1'b1, r_ct, 32'h40100003);
        start(1'b0, 1'b0, 5'h05);
        wait_done(2000);
        // 32 preamble periods of 4 cycles are left out
        chk((full - cyc) inside {[120:136]}, 32'h1);
        $display("test preamble done");
        apb(1'b1, r_ct, 32'h40000003);
        start(1'b0, 1'b0, 5'h05);
        apb(1'b1, r_ct, 32'h3);
        rchk(r_ct, 32'h01000003);
        wait_done(2000);
        flag(got, 1'b1);
        rchk(r_ct, 32'h81000003);
        flag(req_ready, 1'b0);
        $display("test disable done");
        stuck <= 1'b1;
        apb(1'b1, r_ct, 32'h40000003);
        start(1'b1, 1'b0, 5'h05);
        wait_done(2000);
        flag(got, 1'b1);
        rchk(r_ct, 32'hC1000003);
        apb(1'b1, r_ct, 32'h40040003);
        start(1'b1, 1'b0, 5'h05);
        wait_done(600);
        flag(got, 1'b0);
        stuck <= 1'b0;
        rchk(r_ct, 32'hC10C0003);
        rchk(r_st, 32'h3);
        apb(1'b1, r_ct, 32'h40040003);
        rchk(r_ct, 32'hC10C0003);
        apb(1'b1, r_ct, 32'h400C0003);
        rchk(r_ct, 32'hC1040003);
        $display("test fault done");
        apb(1'b1, r_ct, 32'h40000000);
        // Let the clock level launched before the write settle
        @(posedge pclk);
        tick = 0;
        repeat (40) begin
            @(posedge pclk);
            tick += int'(mdc !== 1'b0);
        end
        chk(tick, 32'h00000000);
        flag(req_ready, 1'b0);
        rchk(`MDCS_OFS_CTRL, 32'hC1000000);
        $display("test divider zero done");
        complete_run();
    end
endmodule : mdio_control_status_regs_tb
